// file: common/dicc_ch_if.sv
`timescale 1ns/100ps
interface dicc_ch_if;
   logic tick;
   logic field;
   logic flt;
   logic active;
   logic [31:0] cfg;
   logic proc;
   logic fault;
   logic inval;
   modport top (output tick, field, flt, active, cfg, input proc, fault, inval);
   modport chan (input tick, field, flt, active, cfg, output proc, fault, inval);
endinterface

// file: common/dicc_pkg.sv
// Contract
// - Normal mode forwards the live conditioned level as process value.
// - Simulation mode ignores the field input and outputs the simulated value.
// - Simulated value is one bit with its own valid or invalid status.
// - Current value strategy passes the field level unchanged during a fault.
// - Substitute strategy outputs the configured substitute bit while faulted.
// - A substitute bit is always reported with data invalid status.
// - Last valid strategy freezes the value held just before the fault.
// - Inversion flips the channel level before it is reported.
// - Enabled line monitoring flags faults and applies the error strategy.
// - ON delay in ms suppresses high pulses shorter than the delay.
// - OFF delay in ms postpones each falling edge, stretching pulses.
// - Channel active state follows the module-wide active setting only.
// - Channel n packs process bit at 2(n-1), fault bit next, 1 means error.
// - Channel data goes to the communication unit on a fixed period.
package dicc_pkg;
   localparam int NCH = 7;
   localparam int CLK_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int PERIOD_NS = 6500000;
   localparam int MS_CYC = MS_NS / CLK_NS;
   localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;
   localparam int MS_CNT_W = 18;
   localparam int PER_CNT_W = 21;
   localparam int DLY_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0C;
   localparam logic [7:0] OFF_CH_BASE = 8'h10;
   localparam logic [7:0] OFF_CH_END = 8'h2C;
   localparam int CF_SIM = 0;
   localparam int CF_SIM_VAL = 1;
   localparam int CF_SIM_INV = 2;
   localparam int CF_EMODE = 3;
   localparam int CF_SUBST = 5;
   localparam int CF_INV = 6;
   localparam int CF_LFD = 7;
   localparam int CF_ON = 8;
   localparam int CF_OFF = 16;
   localparam logic [1:0] EM_CURRENT = 2'h0;
   localparam logic [1:0] EM_SUBST = 2'h1;
   localparam logic [1:0] EM_LAST = 2'h2;
   localparam int IRQ_FRAME_BIT = 7;
   localparam logic CTRL_RST = 1'h1;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [31:0] CH_CFG_RST = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verification/dicc_field_model.sv
`timescale 1ns/100ps
module dicc_field_model (
   // Clock
   input wire logic aclk,
   // Contact and line-fault pins
   output logic [dicc_pkg::NCH-1:0] field_in,
   output logic [dicc_pkg::NCH-1:0] fault_in
);
   import dicc_pkg::*;
   initial begin
      field_in = '0;
      fault_in = '0;
   end
   // Contacts move just after an edge so the pin sync never sees a race
   task automatic set_lvl(input int ch, input logic v);
      @(posedge aclk);
      field_in[ch-1] <= v;
   endtask
   task automatic set_flt(input int ch, input logic v);
      @(posedge aclk);
      fault_in[ch-1] <= v;
   endtask
endmodule

// file: verification/tb_dicc_top.sv
`timescale 1ns/100ps
module tb_dicc_top;
   import dicc_pkg::*;
   // Short counts keep the run brief
   localparam int MSC = 100;
   localparam int PER = 200;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, d;
   logic [NCH-1:0] field_in, fault_in, com_inval, ci;
   logic [15:0] com_data, cd;
   logic com_valid, irq;
   int miscompares, compares, gap;

   dicc_field_model fld (.aclk(aclk), .field_in(field_in), .fault_in(fault_in));
   dicc_top #(.MS_CYCLES(MSC), .PERIOD_CYCLES(PER)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .field_in(field_in), .fault_in(fault_in), .com_data(com_data),
      .com_inval(com_inval), .com_valid(com_valid), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic tmo(input string n);
      miscompares++;
      $display("wrong value %s expected answer seen none", n);
      wrap_up();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Latches the delivered word at the pulse edge
   task automatic frame();
      int k;
      for (k = 0; k < 1000; k++) begin
         @(posedge aclk);
         if (com_valid === 1'b1) break;
      end
      if (k == 1000) tmo("com_valid");
      cd = com_data;
      ci = com_inval;
      gap = k + 1;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (k == 100) tmo("bvalid");
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (k == 100) tmo("rvalid");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] r;
      axi_wr(a, v, r);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic [1:0] r;
      axi_rd(a, v, r);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   function automatic logic [7:0] cha(input int n);
      return OFF_CH_BASE + 8'(4 * (n - 1));
   endfunction
   task automatic chk_ch(input int n, input logic p, input logic f, input logic i);
      chk("proc", {31'h0, p}, {31'h0, cd[2*n-2]});
      chk("fault", {31'h0, f}, {31'h0, cd[2*n-1]});
      chk("inval", {31'h0, i}, {31'h0, ci[n-1]});
   endtask

   initial begin
      logic [1:0] r;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      miscompares = 0;
      compares = 0;
      tick(10);
      aresetn <= 1'b1;
      rd(OFF_CTRL, d);
      chk("ctrl", 32'h00000001, d);
      rd(OFF_IRQ_MASK, d);
      chk("mask", 32'h00000000, d);
      rd(cha(7), d);
      chk("cfg7", 32'h00000000, d);
      axi_rd(8'hF0, d, r);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("rdata", 32'h00000000, d);
      axi_wr(8'hF0, 32'hFFFFFFFF, r);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      // Odd channels high, no delay
      for (int n = 1; n <= NCH; n++) fld.set_lvl(n, n % 2);
      frame();
      frame();
      for (int n = 1; n <= NCH; n++) chk_ch(n, n % 2, 1'b0, 1'b0);
      chk("spare", 32'h0, {30'h0, cd[15:14]});
      frame();
      chk("period", 32'(PER), 32'(gap));
      rd(OFF_DATA, d);
      chk("data", {9'h0, ci, cd}, d);
      wr(cha(1), 32'h1 << CF_INV);
      wr(cha(2), (32'h1 << CF_SIM) | (32'h1 << CF_SIM_VAL) | (32'h1 << CF_SIM_INV));
      wr(cha(3), 32'h1 << CF_LFD);
      wr(cha(4), (32'h1 << CF_LFD) | (32'(EM_SUBST) << CF_EMODE) | (32'h1 << CF_SUBST));
      wr(cha(5), (32'h1 << CF_LFD) | (32'(EM_LAST) << CF_EMODE));
      // Fault pin on channel 1 with monitoring off must stay unflagged
      fld.set_flt(1, 1'b1);
      fld.set_flt(3, 1'b1);
      fld.set_flt(4, 1'b1);
      fld.set_flt(5, 1'b1);
      // Fault must be seen before the level moves, else the frozen value is ambiguous
      tick(8);
      fld.set_lvl(5, 1'b0);
      fld.set_lvl(3, 1'b0);
      frame();
      frame();
      chk_ch(1, 1'b0, 1'b0, 1'b0);
      chk_ch(2, 1'b1, 1'b0, 1'b1);
      chk_ch(3, 1'b0, 1'b1, 1'b0);
      chk_ch(4, 1'b1, 1'b1, 1'b1);
      chk_ch(5, 1'b1, 1'b1, 1'b0);
      rd(OFF_IRQ_STAT, d);
      chk("stat", 32'h0000009C, d);
      chk("irq", 32'h0, {31'h0, irq});
      fld.set_flt(5, 1'b0);
      frame();
      frame();
      chk_ch(5, 1'b0, 1'b0, 1'b0);
      wr(OFF_IRQ_MASK, 32'h00000004);
      tick(3);
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_STAT, 32'h000000FF);
      tick(3);
      chk("irq", 32'h0, {31'h0, irq});
      rd(OFF_IRQ_STAT, d);
      chk("stat", 32'h0, {25'h0, d[6:0]});
      wr(OFF_IRQ_MASK, 32'h00000080);
      frame();
      tick(3);
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_MASK, 32'h00000000);
      wr(OFF_CTRL, 32'h00000000);
      frame();
      frame();
      chk("data", 32'h0, {16'h0, cd});
      chk("inval", 32'h7F, {25'h0, ci});
      wr(OFF_CTRL, 32'h00000001);
      wr(cha(6), 32'h4 << CF_ON);
      wr(cha(7), 32'h4 << CF_OFF);
      frame();
      // Short high on 6, fall on 7; a 4 ms delay spans well over one period
      fld.set_lvl(7, 1'b0);
      fld.set_lvl(6, 1'b1);
      tick(100);
      fld.set_lvl(6, 1'b0);
      frame();
      chk_ch(7, 1'b1, 1'b0, 1'b0);
      chk_ch(6, 1'b0, 1'b0, 1'b0);
      frame();
      frame();
      chk_ch(7, 1'b0, 1'b0, 1'b0);
      chk_ch(6, 1'b0, 1'b0, 1'b0);
      fld.set_lvl(6, 1'b1);
      frame();
      chk_ch(6, 1'b0, 1'b0, 1'b0);
      frame();
      frame();
      chk_ch(6, 1'b1, 1'b0, 1'b0);
      wrap_up();
   end
endmodule

// file: verilog/dicc_channel.sv
`timescale 1ns/100ps
module dicc_channel (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Channel link to top
   dicc_ch_if.chan ch
);
   import dicc_pkg::*;
   logic filt_q, hold_q, proc_q, fault_q, inval_q;
   logic [DLY_W-1:0] cnt_q;
   wire sim_w = ch.cfg[CF_SIM];
   wire sim_val_w = ch.cfg[CF_SIM_VAL];
   wire sim_inv_w = ch.cfg[CF_SIM_INV];
   wire [1:0] emode_w = ch.cfg[CF_EMODE +: 2];
   wire subst_w = ch.cfg[CF_SUBST];
   wire [DLY_W-1:0] on_w = ch.cfg[CF_ON +: DLY_W];
   wire [DLY_W-1:0] off_w = ch.cfg[CF_OFF +: DLY_W];
   wire lvl_w = ch.field ^ ch.cfg[CF_INV];
   wire flt_w = ch.cfg[CF_LFD] & ch.flt;
   wire norm_w = ch.active && !sim_w;
   wire [DLY_W-1:0] dly_w = lvl_w ? on_w : off_w;
   wire chg_w = lvl_w != filt_q;
   // Tick granularity: a setting of d ms settles after d-1 to d ms
   wire due_w = ch.tick && ((cnt_q + 8'h01) >= dly_w);
   wire take_w = chg_w && ((dly_w == 8'h00) || due_w);
   wire filt_d = take_w ? lvl_w : filt_q;
   wire [DLY_W-1:0] cnt_inc_w = ch.tick ? cnt_q + 8'h01 : cnt_q;
   wire [DLY_W-1:0] cnt_d = (!chg_w || take_w) ? 8'h00 : cnt_inc_w;
   wire sub_w = flt_w && (emode_w == EM_SUBST);
   wire last_w = flt_w && (emode_w == EM_LAST);
   wire fault_val_w = sub_w ? subst_w : (last_w ? hold_q : filt_q);
   wire proc_d = !ch.active ? 1'b0 : (sim_w ? sim_val_w : fault_val_w);
   wire inval_d = !ch.active ? 1'b1 : (sim_w ? sim_inv_w : sub_w);
   wire fault_d = norm_w && flt_w;
   // Hold tracks only fault-free samples, so it keeps the pre-fault value
   wire hold_d = flt_w ? hold_q : filt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_q <= 1'b0;
         cnt_q <= 8'h00;
         hold_q <= 1'b0;
         proc_q <= 1'b0;
         fault_q <= 1'b0;
         inval_q <= 1'b1;
      end else begin
         filt_q <= filt_d;
         cnt_q <= cnt_d;
         hold_q <= hold_d;
         proc_q <= proc_d;
         fault_q <= fault_d;
         inval_q <= inval_d;
      end
   end
   assign ch.proc = proc_q;
   assign ch.fault = fault_q;
   assign ch.inval = inval_q;

   norm_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && !flt_w |=> proc_q == $past(filt_q) && !inval_q)
      else $error("normal value not forwarded");
   sim_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ch.active && sim_w ##1 ch.active && sim_w |-> proc_q == $past(sim_val_w) && !fault_q)
      else $error("simulated value not output");
   sim_stat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ch.active && sim_w |=> inval_q == $past(sim_inv_w))
      else $error("simulated status wrong");
   cur_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && flt_w && emode_w == EM_CURRENT |=> proc_q == $past(filt_q))
      else $error("current value not passed");
   subst_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && sub_w |=> proc_q == $past(subst_w))
      else $error("substitute bit not output");
   subst_inval_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && sub_w |=> inval_q && fault_q)
      else $error("substitute without invalid status");
   last_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && !flt_w ##1 norm_w && last_w |=> proc_q == $past(filt_q, 2))
      else $error("last valid value not frozen");
   fault_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      norm_w && ch.flt && !ch.cfg[CF_LFD] |=> !fault_q)
      else $error("fault flagged with monitoring off");
   on_dly_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(filt_q) |-> $past(on_w == 8'h00 || ch.tick))
      else $error("rise without on delay expiry");
   off_dly_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(filt_q) |-> $past(off_w == 8'h00 || ch.tick))
      else $error("fall without off delay expiry");
   zero_dly_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dly_w == 8'h00 && chg_w |=> filt_q == $past(ch.field ^ ch.cfg[CF_INV]))
      else $error("zero delay did not pass transition");
   sim_c: cover property (@(posedge aclk) disable iff (!aresetn) ch.active && sim_w ##1 proc_q);
   subst_c: cover property (@(posedge aclk) disable iff (!aresetn) norm_w && sub_w ##1 inval_q);
   last_c: cover property (@(posedge aclk) disable iff (!aresetn) norm_w && last_w [*3]);
endmodule

// file: verilog/dicc_top.sv
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module dicc_top #(
   parameter int unsigned MS_CYCLES = dicc_pkg::MS_CYC,
   parameter int unsigned PERIOD_CYCLES = dicc_pkg::PERIOD_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Field pins
   input wire logic [dicc_pkg::NCH-1:0] field_in,
   input wire logic [dicc_pkg::NCH-1:0] fault_in,
   // Communication unit
   output logic [15:0] com_data,
   output logic [dicc_pkg::NCH-1:0] com_inval,
   output logic com_valid,
   // Interrupt
   output logic irq
);
   import dicc_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   function automatic logic ch_hit(input logic [7:0] a);
      ch_hit = (a >= OFF_CH_BASE) && (a < OFF_CH_END);
   endfunction

   function automatic logic [2:0] ch_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - OFF_CH_BASE;
      ch_idx = d[4:2];
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == OFF_CTRL) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) ||
                (a == OFF_DATA) || ch_hit(a);
   endfunction

   logic [NCH-1:0] fld_s1_q, fld_s2_q, flt_s1_q, flt_s2_q;
   logic [MS_CNT_W-1:0] ms_cnt_q;
   logic [PER_CNT_W-1:0] per_cnt_q;
   logic tick_q;
   logic act_q;
   logic [7:0] mask_q, stat_q;
   logic [31:0] cfg_q [NCH];
   logic [NCH-1:0] proc_w, fault_w, inval_w, fault_prev_q;
   logic [15:0] pack_w;
   logic [15:0] com_data_q;
   logic [NCH-1:0] com_inval_q;
   logic com_valid_q, irq_q;
   logic awready_q, wready_q, aw_have_q, w_have_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;

   // Pins are asynchronous; only the second stage is read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld_s1_q <= '0;
         fld_s2_q <= '0;
         flt_s1_q <= '0;
         flt_s2_q <= '0;
      end else begin
         fld_s1_q <= field_in;
         fld_s2_q <= fld_s1_q;
         flt_s1_q <= fault_in;
         flt_s2_q <= flt_s1_q;
      end
   end

   wire ms_end_w = ms_cnt_q == MS_CNT_W'(MS_CYCLES - 1);
   wire per_hit_w = per_cnt_q == PER_CNT_W'(PERIOD_CYCLES - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt_q <= '0;
         tick_q <= 1'b0;
         per_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_end_w ? '0 : ms_cnt_q + 1'b1;
         tick_q <= ms_end_w;
         per_cnt_q <= per_hit_w ? '0 : per_cnt_q + 1'b1;
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : gen_ch
      dicc_ch_if chif ();
      assign chif.tick = tick_q;
      assign chif.field = fld_s2_q[g];
      assign chif.flt = flt_s2_q[g];
      assign chif.active = act_q;
      assign chif.cfg = cfg_q[g];
      assign proc_w[g] = chif.proc;
      assign fault_w[g] = chif.fault;
      assign inval_w[g] = chif.inval;
      assign pack_w[2*g] = proc_w[g];
      assign pack_w[2*g+1] = fault_w[g];
      dicc_channel u_ch (
         .aclk(aclk),
         .aresetn(aresetn),
         .ch(chif)
      );
   end
   assign pack_w[15:2*NCH] = '0;

   // Delivery runs from its own counter, never from bus reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         com_data_q <= 16'h0000;
         com_inval_q <= '0;
         com_valid_q <= 1'b0;
      end else begin
         com_valid_q <= per_hit_w;
         if (per_hit_w) begin
            com_data_q <= pack_w;
            com_inval_q <= inval_w;
         end
      end
   end

   wire aw_take_w = s_axi_awvalid && awready_q;
   wire w_take_w = s_axi_wvalid && wready_q;
   wire ar_take_w = s_axi_arvalid && arready_q;
   wire wr_w = aw_have_q && w_have_q && !bvalid_q;
   wire [7:0] wa_w = {waddr_q[7:2], 2'b00};
   wire [7:0] ra_w = {s_axi_araddr[7:2], 2'b00};
   wire [31:0] cfg_rd_w = cfg_q[ch_idx(ra_w)];
   wire [31:0] rd_w = (ra_w == OFF_CTRL) ? {31'h00000000, act_q} :
                      (ra_w == OFF_IRQ_STAT) ? {24'h000000, stat_q} :
                      (ra_w == OFF_IRQ_MASK) ? {24'h000000, mask_q} :
                      (ra_w == OFF_DATA) ? {9'h000, com_inval_q, com_data_q} :
                      ch_hit(ra_w) ? cfg_rd_w : 32'h00000000;
   wire [7:0] clr_w = (wr_w && wa_w == OFF_IRQ_STAT && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
   wire [7:0] ev_w = {per_hit_w, 7'(fault_w & ~fault_prev_q)};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         waddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         awready_q <= !aw_have_q && !aw_take_w && !bvalid_q;
         wready_q <= !w_have_q && !w_take_w && !bvalid_q;
         aw_have_q <= aw_take_w || (aw_have_q && !wr_w);
         w_have_q <= w_take_w || (w_have_q && !wr_w);
         bvalid_q <= wr_w || (bvalid_q && !s_axi_bready);
         if (aw_take_w) begin
            waddr_q <= s_axi_awaddr;
         end
         if (w_take_w) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_w) begin
            bresp_q <= reg_hit(wa_w) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= !ar_take_w && !(rvalid_q && !s_axi_rready);
         rvalid_q <= ar_take_w || (rvalid_q && !s_axi_rready);
         if (ar_take_w) begin
            rdata_q <= rd_w;
            rresp_q <= reg_hit(ra_w) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Set wins over a same-cycle write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= CTRL_RST;
         mask_q <= MASK_RST;
         stat_q <= 8'h00;
         fault_prev_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (wr_w && wa_w == OFF_CTRL && wstrb_q[0]) begin
            act_q <= wdata_q[0];
         end
         if (wr_w && wa_w == OFF_IRQ_MASK) begin
            mask_q <= 8'(merge({24'h000000, mask_q}, wdata_q, wstrb_q));
         end
         stat_q <= (stat_q & ~clr_w) | ev_w;
         fault_prev_q <= fault_w;
         irq_q <= |(stat_q & mask_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NCH; i++) begin
            cfg_q[i] <= CH_CFG_RST;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_w && ch_hit(wa_w) && ch_idx(wa_w) == 3'(i)) begin
               cfg_q[i] <= merge(cfg_q[i], wdata_q, wstrb_q);
            end
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign com_data = com_data_q;
   assign com_inval = com_inval_q;
   assign com_valid = com_valid_q;
   assign irq = irq_q;

   // Helper for the period check: cycles since the last delivery
   logic [PER_CNT_W-1:0] gap_q;
   logic seen_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= com_valid_q ? '0 : gap_q + 1'b1;
         seen_q <= seen_q || com_valid_q;
      end
   end

   inactive_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !act_q [*2] |-> pack_w == 16'h0000 && inval_w == '1)
      else $error("inactive module still reports data");
   pack_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
      com_valid_q |-> com_data_q == $past(pack_w) && com_data_q[15:14] == 2'b00)
      else $error("delivered word not packed from channels");
   period_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      com_valid_q && seen_q |-> gap_q == PER_CNT_W'(PERIOD_CYCLES - 1))
      else $error("delivery period wrong");
   fault_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(fault_w[0]) |=> stat_q[0])
      else $error("fault onset not latched");
   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_q == $past(|(stat_q & mask_q)))
      else $error("interrupt level out of step");
   frame_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      com_valid_q |-> stat_q[IRQ_FRAME_BIT])
      else $error("delivery not flagged");
   com_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !com_valid_q |-> $stable(com_data_q) && $stable(com_inval_q))
      else $error("delivered data moved between pulses");
   tick_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tick_q |-> ms_cnt_q == '0)
      else $error("ms tick off its divider wrap");
   per_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      com_valid_q |-> per_cnt_q == '0)
      else $error("delivery off its period wrap");
   // Bus guards: no beat taken while its answer is pending
   wr_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid_q |-> !awready_q && !wready_q)
      else $error("write accepted while response pending");
   rd_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_q |-> !arready_q)
      else $error("read accepted while data pending");
   deliver_c: cover property (@(posedge aclk) disable iff (!aresetn) com_valid_q && |fault_w);
   irq_c: cover property (@(posedge aclk) disable iff (!aresetn) irq_q && stat_q[IRQ_FRAME_BIT]);
endmodule
